// file: pst_pkg.sv
// Purpose: Constants shared by the frame self-test generator and checker
// Assumes: 50 MHz core clock, one byte per transmit strobe
// Notes:   Frame layout is preamble, start delimiter, counting payload
//
// Functional notes
// - Device generates test frames and checks the looped-back copies.
// - By default the transmit strobe comes from an internal divider, no external clock.
// - External clock select high takes the strobe from the reference clock input.
// - Device raises done when the run finishes; software waits for it.
// - Device keeps correct, errored and bad delimiter counters, in high and low halves.
package pst_pkg;
   localparam logic [7:0]  PREAMBLE_BYTE   = 8'h55;
   localparam logic [7:0]  SFD_BYTE        = 8'hD5;
   localparam logic [15:0] PREAMBLE_LEN    = 16'h0007;
   localparam logic [15:0] PAYLOAD_LEN     = 16'h002E;
   localparam logic [15:0] FRAME_LEN       = PREAMBLE_LEN + 16'h0001 + PAYLOAD_LEN;
   localparam logic [15:0] GAP_LEN         = 16'h000C;
   localparam logic [31:0] COUNT_RESET     = 32'h0000_0000;
   localparam int          CLK_MHZ         = 50;
   localparam int          DRAIN_TIME_US   = 100;
   localparam int          DRAIN_CYCLES    = DRAIN_TIME_US * CLK_MHZ;
   localparam int          INT_DIV_DEFAULT = 2;
   typedef enum logic [2:0] {
      PST_IDLE, PST_PRE, PST_SFD, PST_DATA, PST_GAP, PST_DRAIN, PST_DONE
   } pst_state_t;
endpackage : pst_pkg

// file: pst_skid_buf.sv
// Purpose: Two-entry buffer with registered outputs
// Assumes: Single clock, asynchronous active-high reset
// Notes:   Ready on the input drops only when both entries are held
module pst_skid_buf #(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // Fill side
   input  wire logic             in_valid_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  in_ready_o,
   // Drain side
   output logic                  out_valid_o,
   output logic      [WIDTH-1:0] out_data_o,
   input  wire logic             out_ready_i
);
   logic             skid_valid_reg;
   logic [WIDTH-1:0] skid_data_reg;
   wire              pop  = out_valid_o & out_ready_i;
   wire              push = in_valid_i & ~skid_valid_reg;
   wire              head_free = ~out_valid_o | pop;

   assign in_ready_o = ~skid_valid_reg;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         out_valid_o    <= 1'b0;
         out_data_o     <= '0;
         skid_valid_reg <= 1'b0;
         skid_data_reg  <= '0;
      end else if (pop && skid_valid_reg) begin
         out_data_o     <= skid_data_reg;
         skid_valid_reg <= 1'b0;
      end else if (head_free) begin
         out_valid_o <= push;
         if (push) begin
            out_data_o <= in_data_i;
         end
      end else if (push) begin
         skid_data_reg  <= in_data_i;
         skid_valid_reg <= 1'b1;
      end
   end
endmodule : pst_skid_buf

// file: pst_frame_self_test.sv
// Purpose: Line-side test frame generator and loopback checker
// Assumes: Inputs synchronous to clk_i; line accepts a byte on tx_valid_o and tx_ready_i
// Notes:   A run starts on the rising edge of pgen_en_i while self_test_en_i is high
module pst_frame_self_test #(
   parameter int DRAIN_CYCLES = pst_pkg::DRAIN_CYCLES,
   parameter int INT_DIV      = pst_pkg::INT_DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   // Configuration
   input  wire logic        frame_cnt_en_i,
   input  wire logic        self_test_en_i,
   input  wire logic        pgen_en_i,
   input  wire logic        ext_clk_sel_i,
   input  wire logic [15:0] frame_count_lo_i,
   input  wire logic [15:0] frame_count_hi_i,
   input  wire logic        tx_reference_clock_in_i,
   // Line transmit
   output logic             tx_valid_o,
   output logic      [7:0]  tx_data_o,
   output logic             tx_last_o,
   input  wire logic        tx_ready_i,
   // Line receive
   input  wire logic        rx_dv_i,
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   // Status
   output logic             busy_o,
   output logic             done_o,
   output logic      [15:0] correct_cnt_hi_o,
   output logic      [15:0] correct_cnt_lo_o,
   output logic      [15:0] error_cnt_hi_o,
   output logic      [15:0] error_cnt_lo_o,
   output logic      [15:0] bad_sfd_cnt_hi_o,
   output logic      [15:0] bad_sfd_cnt_lo_o
);
   //--------------------------------------------------------------
   // Transmit strobe source
   //--------------------------------------------------------------
   logic [7:0] div_reg;
   logic       ref_prev_reg;
   logic       tick_pend_reg;
   wire        int_tick = (div_reg == 8'(INT_DIV - 1));
   wire        ext_tick = tx_reference_clock_in_i & ~ref_prev_reg;
   wire        tick     = ext_clk_sel_i ? ext_tick : int_tick;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_reg      <= 8'h00;
         ref_prev_reg <= 1'b0;
      end else begin
         div_reg      <= int_tick ? 8'h00 : div_reg + 8'h01;
         ref_prev_reg <= tx_reference_clock_in_i;
      end
   end

   //--------------------------------------------------------------
   // Generator
   //--------------------------------------------------------------
   pst_pkg::pst_state_t state_reg, state_next;
   logic [15:0] pos_reg;
   logic [31:0] sent_reg;
   logic [31:0] drain_reg;
   logic        pgen_prev_reg;
   logic        buf_ready;
   logic [31:0] total_next;

   wire [31:0] target   = {frame_count_hi_i, frame_count_lo_i};
   wire        start    = pgen_en_i & ~pgen_prev_reg & self_test_en_i;
   wire        gen_go   = tick_pend_reg & buf_ready;
   wire        last_pre = (pos_reg == pst_pkg::PREAMBLE_LEN - 16'h0001);
   wire        last_dat = (pos_reg == pst_pkg::PAYLOAD_LEN - 16'h0001);
   wire        last_gap = (pos_reg == pst_pkg::GAP_LEN - 16'h0001);
   wire        all_sent = frame_cnt_en_i ? (sent_reg == target) : ~pgen_en_i;
   wire        in_byte  = (state_reg == pst_pkg::PST_PRE) || (state_reg == pst_pkg::PST_SFD)
                          || (state_reg == pst_pkg::PST_DATA);
   wire        gen_push = in_byte & gen_go;
   wire [7:0]  gen_byte = (state_reg == pst_pkg::PST_PRE) ? pst_pkg::PREAMBLE_BYTE :
                          (state_reg == pst_pkg::PST_SFD) ? pst_pkg::SFD_BYTE : pos_reg[7:0];
   wire        gen_last = (state_reg == pst_pkg::PST_DATA) & last_dat;
   wire        returned = frame_cnt_en_i & (total_next == sent_reg);
   wire        drain_end = returned | (drain_reg == 32'(DRAIN_CYCLES - 1));

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pst_pkg::PST_IDLE,
         pst_pkg::PST_DONE:  if (start) state_next = (frame_cnt_en_i && target == 32'h0) ?
                                                     pst_pkg::PST_DRAIN : pst_pkg::PST_PRE;
         pst_pkg::PST_PRE:   if (gen_go && last_pre) state_next = pst_pkg::PST_SFD;
         pst_pkg::PST_SFD:   if (gen_go) state_next = pst_pkg::PST_DATA;
         pst_pkg::PST_DATA:  if (gen_go && last_dat) state_next = pst_pkg::PST_GAP;
         pst_pkg::PST_GAP:   if (gen_go && last_gap) state_next = all_sent ?
                                                     pst_pkg::PST_DRAIN : pst_pkg::PST_PRE;
         pst_pkg::PST_DRAIN: if (drain_end && !tx_valid_o) state_next = pst_pkg::PST_DONE;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg     <= pst_pkg::PST_IDLE;
         pos_reg       <= 16'h0000;
         sent_reg      <= pst_pkg::COUNT_RESET;
         drain_reg     <= 32'h0;
         pgen_prev_reg <= 1'b0;
         tick_pend_reg <= 1'b0;
         busy_o        <= 1'b0;
         done_o        <= 1'b0;
      end else begin
         state_reg     <= state_next;
         pgen_prev_reg <= pgen_en_i;
         tick_pend_reg <= tick | (tick_pend_reg & ~gen_go);
         pos_reg       <= (state_next != state_reg) ? 16'h0000 : pos_reg + {15'h0, gen_go};
         drain_reg     <= (state_reg == pst_pkg::PST_DRAIN) ? drain_reg + 32'h1 : 32'h0;
         busy_o        <= (state_next != pst_pkg::PST_IDLE) && (state_next != pst_pkg::PST_DONE);
         done_o        <= (state_next == pst_pkg::PST_DONE);
         if (start) begin
            sent_reg <= pst_pkg::COUNT_RESET;
         end else if (gen_push && gen_last) begin
            sent_reg <= sent_reg + 32'h1;
         end
      end
   end

   //--------------------------------------------------------------
   // Transmit buffer
   //--------------------------------------------------------------
   pst_skid_buf #(.WIDTH(9)) u_tx_buf (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (gen_push),
      .in_data_i   ({gen_last, gen_byte}),
      .in_ready_o  (buf_ready),
      .out_valid_o (tx_valid_o),
      .out_data_o  ({tx_last_o, tx_data_o}),
      .out_ready_i (tx_ready_i)
   );

   //--------------------------------------------------------------
   // Checker
   //--------------------------------------------------------------
   logic [15:0] rx_idx_reg;
   logic        rx_in_reg;
   logic        rx_bad_sfd_reg;
   logic        rx_err_reg;
   logic [31:0] correct_reg, error_reg, bad_sfd_reg;

   wire        counting = busy_o;
   wire        rx_byte  = rx_dv_i & rx_valid_i;
   wire        rx_end   = rx_in_reg & ~rx_dv_i & counting;
   // First byte of a frame is index 0, whatever the last frame left behind
   wire [15:0] rx_cur   = rx_in_reg ? rx_idx_reg : 16'h0000;
   wire        is_sfd   = (rx_cur == pst_pkg::PREAMBLE_LEN);
   wire [7:0]  rx_want  = (rx_cur < pst_pkg::PREAMBLE_LEN) ? pst_pkg::PREAMBLE_BYTE :
                          8'(rx_cur - pst_pkg::PREAMBLE_LEN - 16'h0001);
   wire        sfd_bad  = rx_byte & is_sfd & (rx_data_i != pst_pkg::SFD_BYTE);
   wire        byte_bad = rx_byte & ~is_sfd & (rx_data_i != rx_want);
   wire        len_bad  = (rx_idx_reg != pst_pkg::FRAME_LEN);
   wire        hit_bad  = rx_end & rx_bad_sfd_reg;
   wire        hit_err  = rx_end & ~rx_bad_sfd_reg & (rx_err_reg | len_bad);
   wire        hit_ok   = rx_end & ~rx_bad_sfd_reg & ~rx_err_reg & ~len_bad;

   assign total_next = correct_reg + error_reg + bad_sfd_reg
                       + {31'h0, hit_ok} + {31'h0, hit_err} + {31'h0, hit_bad};

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rx_idx_reg     <= 16'h0000;
         rx_in_reg      <= 1'b0;
         rx_bad_sfd_reg <= 1'b0;
         rx_err_reg     <= 1'b0;
      end else begin
         rx_in_reg <= rx_dv_i;
         if (!rx_in_reg) begin
            rx_idx_reg     <= {15'h0, rx_byte};
            rx_bad_sfd_reg <= 1'b0;
            rx_err_reg     <= byte_bad;
         end else begin
            rx_idx_reg     <= rx_idx_reg + {15'h0, rx_byte};
            rx_bad_sfd_reg <= rx_bad_sfd_reg | sfd_bad;
            rx_err_reg     <= rx_err_reg | byte_bad;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         correct_reg <= pst_pkg::COUNT_RESET;
         error_reg   <= pst_pkg::COUNT_RESET;
         bad_sfd_reg <= pst_pkg::COUNT_RESET;
      end else if (start) begin
         correct_reg <= pst_pkg::COUNT_RESET;
         error_reg   <= pst_pkg::COUNT_RESET;
         bad_sfd_reg <= pst_pkg::COUNT_RESET;
      end else begin
         correct_reg <= correct_reg + {31'h0, hit_ok};
         error_reg   <= error_reg + {31'h0, hit_err};
         bad_sfd_reg <= bad_sfd_reg + {31'h0, hit_bad};
      end
   end

   assign correct_cnt_hi_o = correct_reg[31:16];
   assign correct_cnt_lo_o = correct_reg[15:0];
   assign error_cnt_hi_o   = error_reg[31:16];
   assign error_cnt_lo_o   = error_reg[15:0];
   assign bad_sfd_cnt_hi_o = bad_sfd_reg[31:16];
   assign bad_sfd_cnt_lo_o = bad_sfd_reg[15:0];

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   AST_INT_STROBE: assert property (!ext_clk_sel_i && $past(!ext_clk_sel_i) && tick |=> !tick)
      else $error("internal strobe fired on consecutive cycles");
   AST_EXT_STROBE: assert property (ext_clk_sel_i && tick |-> $rose(tx_reference_clock_in_i))
      else $error("external strobe without reference clock edge");
   AST_FIRST_BYTE: assert property (start && target != 32'h0
                                    && (state_reg == pst_pkg::PST_IDLE || state_reg == pst_pkg::PST_DONE)
                                    |=> state_reg == pst_pkg::PST_PRE)
      else $error("generator did not start a frame");
   AST_DONE_ONLY_AFTER_DRAIN: assert property ($rose(done_o) |-> $past(state_reg) == pst_pkg::PST_DRAIN
                                               && !$past(tx_valid_o))
      else $error("done raised before drain finished");
   AST_DONE_HOLDS: assert property (done_o && !start |=> done_o)
      else $error("done dropped without a new start");
   AST_EXACT_COUNT: assert property ($rose(done_o) && frame_cnt_en_i |-> sent_reg == target)
      else $error("sent frame count differs from programmed count");
   AST_CLEAR_ON_START: assert property (start |=> correct_reg == 32'h0 && error_reg == 32'h0
                                        && bad_sfd_reg == 32'h0)
      else $error("result counters not cleared at start");
   AST_ONE_RESULT: assert property (rx_end |=> (correct_reg + error_reg + bad_sfd_reg)
                                    == $past(correct_reg + error_reg + bad_sfd_reg) + 32'h1)
      else $error("frame end did not bump exactly one counter");
endmodule : pst_frame_self_test

// file: pst_loop_model.sv
// Purpose: Loopback plug model: returns every transmitted frame on the receive side
// Assumes: One byte per accepted transfer, a frame ends on the flagged last byte
// Notes:   fault_i 1 corrupts a payload byte, 2 corrupts the delimiter
module pst_loop_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // Line transmit side
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_last_i,
   output logic            tx_ready_o,
   // Line receive side
   output logic            rx_dv_o,
   output logic            rx_valid_o,
   output logic      [7:0] rx_data_o,
   // Scenario control and counts
   input  wire logic       stall_i,
   input  wire logic [1:0] fault_i,
   output int              tx_frames_o,
   output int              rx_frames_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] q[$];
   logic [8:0] e;
   logic       in_frame = 1'b0;
   logic       gap = 1'b0;
   logic       skip = 1'b0;
   int         idx = 0;
   initial begin
      tx_ready_o = 1'b0; rx_dv_o = 1'b0; rx_valid_o = 1'b0; rx_data_o = 8'h00;
      tx_frames_o = 0; rx_frames_o = 0;
   end
   always @(posedge clk_i) begin
      if (!reset_i && tx_valid_i && tx_ready_o) begin
         q.push_back({tx_last_i, tx_data_i});
         if (tx_last_i) begin
            tx_frames_o++;
         end
      end
   end
   // Replay only whole frames, with a dead cycle between them
   always @(negedge clk_i) begin
      tx_ready_o <= reset_i ? 1'b0 : (stall_i ? ~tx_ready_o : 1'b1);
      skip = stall_i & ~skip;
      if (reset_i || gap || !(in_frame || tx_frames_o > rx_frames_o)) begin
         rx_dv_o <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_data_o <= ~rx_data_o;
         gap = 1'b0;
      end else if (skip) begin
         rx_dv_o <= 1'b1;
         rx_valid_o <= 1'b0;
         rx_data_o <= ~rx_data_o;
         in_frame = 1'b1;
      end else begin
         e = q.pop_front();
         if (fault_i == 2'h1 && idx == 20) e[7:0] = ~e[7:0];
         if (fault_i == 2'h2 && idx == 7) e[7:0] = 8'h00;
         rx_dv_o <= 1'b1;
         rx_valid_o <= 1'b1;
         rx_data_o <= e[7:0];
         idx = e[8] ? 0 : idx + 1;
         in_frame = ~e[8];
         gap = e[8];
         if (e[8]) rx_frames_o++;
      end
   end
endmodule : pst_loop_model

// file: pst_frame_self_test_test.sv
// Purpose: Self-checking bench for the frame self-test block
// Assumes: Loopback model on the line side, shortened drain time
// Notes:   Inputs change on the falling clock edge
module pst_frame_self_test_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, reset_i = 1'b1, frame_cnt_en = 1'b0, self_test_en = 1'b0, pgen_en = 1'b0;
   logic        ext_sel = 1'b0, ref_clk = 1'b0, ref_run = 1'b0, stall = 1'b0;
   logic [15:0] cnt_lo = 16'h0000, cnt_hi = 16'h0000;
   logic [1:0]  fault = 2'h0;
   logic        tx_valid, tx_last, tx_ready, rx_dv, rx_valid, busy, done;
   logic [7:0]  tx_data, rx_data;
   logic [15:0] ok_hi, ok_lo, er_hi, er_lo, bs_hi, bs_lo;
   int          txf, rxf, t0, r0;
   int          err_total = 0;
   int          comparisons = 0;
   initial forever #10 clk_i = ~clk_i;
   always @(negedge clk_i) if (ref_run) ref_clk <= ~ref_clk;
   pst_frame_self_test #(.DRAIN_CYCLES(200), .INT_DIV(2)) DUT (
      .clk_i(clk_i), .reset_i(reset_i), .frame_cnt_en_i(frame_cnt_en), .self_test_en_i(self_test_en),
      .pgen_en_i(pgen_en), .ext_clk_sel_i(ext_sel), .frame_count_lo_i(cnt_lo), .frame_count_hi_i(cnt_hi),
      .tx_reference_clock_in_i(ref_clk), .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last),
      .tx_ready_i(tx_ready), .rx_dv_i(rx_dv), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .busy_o(busy),
      .done_o(done), .correct_cnt_hi_o(ok_hi), .correct_cnt_lo_o(ok_lo), .error_cnt_hi_o(er_hi),
      .error_cnt_lo_o(er_lo), .bad_sfd_cnt_hi_o(bs_hi), .bad_sfd_cnt_lo_o(bs_lo));
   pst_loop_model MDL (
      .clk_i(clk_i), .reset_i(reset_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
      .tx_ready_o(tx_ready), .rx_dv_o(rx_dv), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
      .stall_i(stall), .fault_i(fault), .tx_frames_o(txf), .rx_frames_o(rxf));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check
   task wrap_up;
      if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task counts(input logic [31:0] ok, input logic [31:0] er, input logic [31:0] bs);
      check("correct count", {ok_hi, ok_lo}, ok);
      check("error count", {er_hi, er_lo}, er);
      check("bad delimiter count", {bs_hi, bs_lo}, bs);
   endtask : counts
   task start_run(input logic [31:0] count);
      @(negedge clk_i);
      pgen_en = 1'b0;
      // Link taken as already forced: fixed speed, full duplex, fixed crossover, master
      cnt_lo = count[15:0];
      cnt_hi = count[31:16];
      t0 = txf;
      r0 = rxf;
      @(negedge clk_i) frame_cnt_en = 1'b1;
      @(negedge clk_i) self_test_en = 1'b1;
      @(negedge clk_i) pgen_en = 1'b1;
      // One edge after start: a zero count is done one edge later
      @(negedge clk_i);
      check("done cleared at start", done, 1'b0);
      check("busy at start", busy, 1'b1);
      counts(0, 0, 0);
   endtask : start_run
   task finish_run(input logic [31:0] count);
      for (int i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk_i);
      check("done", done, 1'b1);
      check("frames sent", txf - t0, count);
      check("frames looped before done", rxf - r0, count);
   endtask : finish_run
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      check("done after reset", done, 1'b0);
      check("tx valid after reset", tx_valid, 1'b0);
      counts(0, 0, 0);
   endtask : t_reset
   task t_internal_clock;
      start_run(32'h0000_0003);
      finish_run(32'h0000_0003);
      counts(3, 0, 0);
   endtask : t_internal_clock
   task t_external_clock;
      ext_sel = 1'b1;
      start_run(32'h0000_0002);
      repeat (100) @(negedge clk_i);
      check("no frame without reference clock", txf - t0, 0);
      check("line idle without reference clock", tx_valid, 1'b0);
      ref_run = 1'b1;
      finish_run(32'h0000_0002);
      counts(2, 0, 0);
      ref_run = 1'b0;
      ext_sel = 1'b0;
   endtask : t_external_clock
   task t_payload_error;
      stall = 1'b1;
      fault = 2'h1;
      start_run(32'h0000_0002);
      finish_run(32'h0000_0002);
      counts(0, 2, 0);
   endtask : t_payload_error
   task t_bad_delimiter;
      fault = 2'h2;
      start_run(32'h0000_0002);
      finish_run(32'h0000_0002);
      counts(0, 0, 2);
      fault = 2'h0;
      stall = 1'b0;
   endtask : t_bad_delimiter
   task t_zero_count;
      start_run(32'h0000_0000);
      finish_run(32'h0000_0000);
      counts(0, 0, 0);
   endtask : t_zero_count
   task t_free_run;
      @(negedge clk_i);
      pgen_en = 1'b0;
      frame_cnt_en = 1'b0;
      t0 = txf;
      r0 = rxf;
      @(negedge clk_i) pgen_en = 1'b1;
      // Frame period is (54 + 12) strobes of 2 cycles: the drop lands in the third frame
      repeat (300) @(negedge clk_i);
      check("busy while free running", busy, 1'b1);
      pgen_en = 1'b0;
      finish_run(32'h0000_0003);
      counts(3, 0, 0);
   endtask : t_free_run
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (6) @(negedge clk_i);
      reset_i = 1'b0;
      @(negedge clk_i);
      t_reset();
      t_internal_clock();
      t_external_clock();
      t_payload_error();
      t_bad_delimiter();
      t_zero_count();
      t_free_run();
      wrap_up();
   end
   initial begin
      #1_000_000;
      err_total++;
      wrap_up();
   end
endmodule : pst_frame_self_test_test
